// File: hdl/hpps_params.svh
`ifndef HPPS_PARAMS_SVH
`define HPPS_PARAMS_SVH
// Register offsets (byte addresses, one word each)
`define HPPS_OFF_CTRL 8'h00
`define HPPS_OFF_STATUS 8'h04
`define HPPS_OFF_IRQ_STAT 8'h08
`define HPPS_OFF_IRQ_MASK 8'h0c
`define HPPS_OFF_HUB 8'h10
// Control register fields
`define HPPS_CTRL_SET_POWER 0
`define HPPS_CTRL_CLR_POWER 1
`define HPPS_CTRL_ENUM 2
`define HPPS_CTRL_SUSPEND 3
`define HPPS_CTRL_RESUME 4
`define HPPS_CTRL_CLR_OC_CHG 5
// Status register fields
`define HPPS_ST_POWER_ON 0
`define HPPS_ST_SELF 1
`define HPPS_ST_SUPPLY_GOOD 2
`define HPPS_ST_OC 3
`define HPPS_ST_CLK6 4
`define HPPS_ST_NORMAL 5
`define HPPS_ST_ENUM 6
`define HPPS_ST_SUSPEND 7
// Hub status / change field bit positions
`define HPPS_HUB_OC_BIT 1
`define HPPS_HUB_CHG_SHIFT 16
// Interrupt events
`define HPPS_IRQ_OC 0
`define HPPS_IRQ_SUPPLY 1
`define HPPS_IRQ_MODE 2
`define HPPS_IRQ_W 3
`define HPPS_IRQ_RST 3'h0
// Clock frequencies in MHz
`define HPPS_CLK_SLOW_MHZ 6
`define HPPS_CLK_FAST_MHZ 48
`define HPPS_NUM_DOWN 4
`endif

// File: hdl/hpps_pkg.sv
package hpps_pkg;
    typedef enum logic [1:0] {HPPS_UNCONF, HPPS_ENUM, HPPS_SUSP} hpps_hub_state_t;
    typedef logic [7:0] hpps_addr_t;
    typedef logic [31:0] hpps_word_t;
endpackage

// File: hdl/hpps_sync.sv
`timescale 1ns/1ns
module hpps_sync (
    input wire logic core_clk_i,
    input wire logic sys_rst_i,
    input wire logic [2:0] raw_i,
    hpps_sync_if.src out
);
    logic [2:0] s1_q;
    logic [2:0] s2_q;
    // Overcurrent resets high so power is not latched off at start
    always_ff @(posedge core_clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            s1_q <= 3'h1;
            s2_q <= 3'h1;
        end
        else
        begin
            s1_q <= raw_i;
            s2_q <= s1_q;
        end
    end
    assign out.oc_n = s2_q[0];
    assign out.lps = s2_q[1];
    assign out.self_powered = s2_q[2];
endmodule // hpps_sync

// File: hdl/hpps_sync_if.sv
`timescale 1ns/1ns
interface hpps_sync_if;
    logic oc_n;
    logic lps;
    logic self_powered;
    modport src (output oc_n, output lps, output self_powered);
    modport dst (input oc_n, input lps, input self_powered);
endinterface

// File: hdl/hpps_top.sv
// Design decisions made here: the placing of the registers and the strobed register port.
`timescale 1ns/1ns
`include "hpps_params.svh"
// Summary of operation
// - Overcurrent drops port power and is reported in status fields.
// - Power mode input high selects self-powered, low bus-powered.
// - Enumeration indicator goes on once the hub is enumerated.
// - Enumeration indicator goes off whenever the hub is suspended.
// - Clock select low expects 48 MHz, high runs from 6 MHz.
// - In self-powered mode the local supply status is sampled.
// - Test input pulled up; high means normal operation.
// - One upstream port 0 and four downstream ports 1 to 4.
// - A low level on the overcurrent input means overcurrent.
// - Overcurrent sets hub status bit and hub change bit.
// - Power on only by set request; off at reset, overcurrent, clear.
module hpps_top (
    input wire logic core_clk_i,
    input wire logic sys_rst_i,
    input wire logic overcurrent_in_n_i,
    input wire logic local_supply_good_i,
    input wire logic self_bus_i,
    input wire logic clk_sel_i,
    input wire logic test_i,
    input wire logic xtal_in_i,
    output logic xtal_out_o,
    input wire logic upstream_plus_i,
    input wire logic upstream_minus_i,
    output logic upstream_plus_o,
    output logic upstream_minus_o,
    output logic upstream_oe_o,
    input wire logic [`HPPS_NUM_DOWN-1:0] downstream_plus_i,
    input wire logic [`HPPS_NUM_DOWN-1:0] downstream_minus_i,
    output logic [`HPPS_NUM_DOWN-1:0] downstream_plus_o,
    output logic [`HPPS_NUM_DOWN-1:0] downstream_minus_o,
    output logic [`HPPS_NUM_DOWN-1:0] downstream_oe_o,
    output logic port_power_switch_n_o,
    output logic enum_led_o,
    output logic irq_o,
    input wire hpps_pkg::hpps_addr_t addr_i,
    input wire hpps_pkg::hpps_word_t wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output hpps_pkg::hpps_word_t rdata_o
);
    hpps_sync_if sy ();
    hpps_pkg::hpps_hub_state_t st_q;
    logic power_on_q;
    logic oc_chg_q;
    logic supply_good_q;
    logic self_q;
    logic clk6_q;
    logic normal_q;
    logic xtal_q;
    logic [`HPPS_IRQ_W-1:0] irq_stat_q;
    logic [`HPPS_IRQ_W-1:0] irq_mask_q;
    logic [`HPPS_IRQ_W-1:0] ev;
    logic supply_prev_q;
    logic self_prev_q;
    logic oc_act;
    logic wr_ctrl;
    logic [31:0] hub_word;
    logic [7:0] status_word;

    // **********************************
    // Input synchronisers
    // **********************************
    hpps_sync u_sync (
        .core_clk_i(core_clk_i),
        .sys_rst_i(sys_rst_i),
        .raw_i({self_bus_i, local_supply_good_i, overcurrent_in_n_i}),
        .out(sy.src)
    );

    function automatic logic hit(input hpps_pkg::hpps_addr_t a, input hpps_pkg::hpps_addr_t off);
        hit = (a == off);
    endfunction

    assign oc_act = !sy.oc_n;
    assign wr_ctrl = wr_i && hit(addr_i, `HPPS_OFF_CTRL);

    // **********************************
    // Port power switch
    // **********************************
    // Overcurrent wins over a simultaneous set request so the switch never pulses on
    always_ff @(posedge core_clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
            power_on_q <= 1'b0;
        else if (oc_act)
            power_on_q <= 1'b0;
        else if (wr_ctrl && wdata_i[`HPPS_CTRL_CLR_POWER])
            power_on_q <= 1'b0;
        else if (wr_ctrl && wdata_i[`HPPS_CTRL_SET_POWER])
            power_on_q <= 1'b1;
    end

    always_ff @(posedge core_clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
            port_power_switch_n_o <= 1'b1;
        else
            port_power_switch_n_o <= !(power_on_q && !oc_act);
    end

    // Change bit: set wins over clear
    always_ff @(posedge core_clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
            oc_chg_q <= 1'b0;
        else if (oc_act)
            oc_chg_q <= 1'b1;
        else if (wr_ctrl && wdata_i[`HPPS_CTRL_CLR_OC_CHG])
            oc_chg_q <= 1'b0;
    end

    // **********************************
    // Power mode and local supply
    // **********************************
    always_ff @(posedge core_clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            self_q <= 1'b0;
            supply_good_q <= 1'b0;
        end
        else
        begin
            self_q <= sy.self_powered;
            // Bus-powered hubs have no local supply to watch
            supply_good_q <= sy.self_powered ? sy.lps : 1'b0;
        end
    end

    // Straps sampled every cycle after reset release; the async reset loads clock select low and normal mode high
    always_ff @(posedge core_clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            clk6_q <= 1'b0;
            normal_q <= 1'b1;
        end
        else
        begin
            clk6_q <= clk_sel_i;
            normal_q <= test_i;
        end
    end

    // Oscillator amplifier stand-in: inverted input
    always_ff @(posedge core_clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
            xtal_q <= 1'b0;
        else
            xtal_q <= !xtal_in_i;
    end
    assign xtal_out_o = xtal_q;

    // **********************************
    // Enumeration state
    // **********************************
    always_ff @(posedge core_clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
            st_q <= hpps_pkg::HPPS_UNCONF;
        else if (wr_ctrl)
        begin
            unique case (st_q)
                hpps_pkg::HPPS_UNCONF:
                    if (wdata_i[`HPPS_CTRL_ENUM])
                        st_q <= hpps_pkg::HPPS_ENUM;
                hpps_pkg::HPPS_ENUM:
                    if (wdata_i[`HPPS_CTRL_SUSPEND])
                        st_q <= hpps_pkg::HPPS_SUSP;
                hpps_pkg::HPPS_SUSP:
                    if (wdata_i[`HPPS_CTRL_RESUME])
                        st_q <= hpps_pkg::HPPS_ENUM;
                default:
                    st_q <= hpps_pkg::HPPS_UNCONF;
            endcase
        end
    end

    always_ff @(posedge core_clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
            enum_led_o <= 1'b0;
        else
            enum_led_o <= (st_q == hpps_pkg::HPPS_ENUM);
    end

    // **********************************
    // USB pads
    // **********************************
    // Repeater is outside this block: pads stay undriven (receive only)
    genvar g;
    generate
        for (g = 0; g < `HPPS_NUM_DOWN; g++)
        begin : g_down
            always_ff @(posedge core_clk_i or posedge sys_rst_i)
            begin
                if (sys_rst_i)
                begin
                    downstream_plus_o[g] <= 1'b0;
                    downstream_minus_o[g] <= 1'b0;
                    downstream_oe_o[g] <= 1'b0;
                end
                else
                begin
                    downstream_plus_o[g] <= 1'b0;
                    downstream_minus_o[g] <= 1'b0;
                    downstream_oe_o[g] <= 1'b0;
                end
            end
        end
    endgenerate

    always_ff @(posedge core_clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            upstream_plus_o <= 1'b0;
            upstream_minus_o <= 1'b0;
            upstream_oe_o <= 1'b0;
        end
        else
        begin
            upstream_plus_o <= 1'b0;
            upstream_minus_o <= 1'b0;
            upstream_oe_o <= 1'b0;
        end
    end

    // **********************************
    // Interrupts
    // **********************************
    always_ff @(posedge core_clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            supply_prev_q <= 1'b0;
            self_prev_q <= 1'b0;
        end
        else
        begin
            supply_prev_q <= supply_good_q;
            self_prev_q <= self_q;
        end
    end

    always_comb
    begin
        ev = '0;
        ev[`HPPS_IRQ_OC] = oc_act;
        ev[`HPPS_IRQ_SUPPLY] = supply_prev_q ^ supply_good_q;
        ev[`HPPS_IRQ_MODE] = self_prev_q ^ self_q;
    end

    // Set wins over write-one-to-clear
    always_ff @(posedge core_clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
            irq_stat_q <= `HPPS_IRQ_RST;
        else if (wr_i && hit(addr_i, `HPPS_OFF_IRQ_STAT))
            irq_stat_q <= (irq_stat_q & ~wdata_i[`HPPS_IRQ_W-1:0]) | ev;
        else
            irq_stat_q <= irq_stat_q | ev;
    end

    always_ff @(posedge core_clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
            irq_mask_q <= `HPPS_IRQ_RST;
        else if (wr_i && hit(addr_i, `HPPS_OFF_IRQ_MASK))
            irq_mask_q <= wdata_i[`HPPS_IRQ_W-1:0];
    end

    always_ff @(posedge core_clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
            irq_o <= 1'b0;
        else
            irq_o <= |(irq_stat_q & irq_mask_q);
    end

    // **********************************
    // Register read
    // **********************************
    always_comb
    begin
        hub_word = '0;
        hub_word[`HPPS_HUB_OC_BIT] = oc_act;
        hub_word[`HPPS_HUB_CHG_SHIFT + `HPPS_HUB_OC_BIT] = oc_chg_q;
        status_word = '0;
        status_word[`HPPS_ST_POWER_ON] = power_on_q;
        status_word[`HPPS_ST_SELF] = self_q;
        status_word[`HPPS_ST_SUPPLY_GOOD] = supply_good_q;
        status_word[`HPPS_ST_OC] = oc_act;
        status_word[`HPPS_ST_CLK6] = clk6_q;
        status_word[`HPPS_ST_NORMAL] = normal_q;
        status_word[`HPPS_ST_ENUM] = (st_q == hpps_pkg::HPPS_ENUM);
        status_word[`HPPS_ST_SUSPEND] = (st_q == hpps_pkg::HPPS_SUSP);
    end

    always_ff @(posedge core_clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
            rdata_o <= '0;
        else if (!rd_i)
            rdata_o <= '0;
        else if (hit(addr_i, `HPPS_OFF_STATUS))
            rdata_o <= {24'h000000, status_word};
        else if (hit(addr_i, `HPPS_OFF_IRQ_STAT))
            rdata_o <= {29'h0, irq_stat_q};
        else if (hit(addr_i, `HPPS_OFF_IRQ_MASK))
            rdata_o <= {29'h0, irq_mask_q};
        else if (hit(addr_i, `HPPS_OFF_HUB))
            rdata_o <= hub_word;
        else
            rdata_o <= '0;
    end

    // **********************************
    // Checks
    // **********************************
    chk_oc_power_off: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
        !sy.oc_n |=> port_power_switch_n_o) else $error("power on during overcurrent");
    chk_oc_sync_lag: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
        !overcurrent_in_n_i ##1 !overcurrent_in_n_i |=> oc_act) else $error("sync lag wrong");
    chk_oc_change_set: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
        oc_act |=> oc_chg_q) else $error("change bit not set");
    chk_power_only_set: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
        $rose(power_on_q) |-> $past(wr_ctrl) && $past(wdata_i[`HPPS_CTRL_SET_POWER]))
        else $error("power rose unasked");
    chk_power_clear: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
        wr_ctrl && wdata_i[`HPPS_CTRL_CLR_POWER] |=> !power_on_q ##1 port_power_switch_n_o)
        else $error("clear failed");
    chk_mode_follow: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
        sy.self_powered |=> self_q) else $error("mode not self");
    chk_bus_no_supply: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
        !sy.self_powered |=> !supply_good_q) else $error("supply seen in bus mode");
    chk_led_suspend: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
        st_q == hpps_pkg::HPPS_SUSP |=> !enum_led_o) else $error("led on in suspend");
    chk_led_enum: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
        st_q == hpps_pkg::HPPS_ENUM |=> enum_led_o) else $error("led off when enumerated");
endmodule // hpps_top

// File: sim/hpps_switch_model.sv
`timescale 1ns/1ns
// ****************************************
// Ganged port switch with fault flag
// ****************************************
module hpps_switch_model (
    input wire logic core_clk_i,
    input wire logic sys_rst_i,
    input wire logic port_power_switch_n_i,
    input wire logic fault_i,
    output logic overcurrent_in_n_o
);
    logic tripped_q;
    // An unpowered short draws nothing, so the flag only trips while the switch is on,
    // then stays latched until the fault is removed
    always_ff @(posedge core_clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
            tripped_q <= 1'b0;
        else if (!fault_i)
            tripped_q <= 1'b0;
        else if (!port_power_switch_n_i)
            tripped_q <= 1'b1;
    end
    assign overcurrent_in_n_o = ~tripped_q;
endmodule // hpps_switch_model

// File: sim/tb_hub_port_power_status_control.sv
`timescale 1ns/1ns
`include "hpps_params.svh"
module tb_hub_port_power_status_control;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic sup = 1'b1, self_p = 1'b1, csel = 1'b0, test = 1'b1, xin = 1'b0, fault = 1'b0;
    logic up_p = 1'b0, up_m = 1'b0, wr = 1'b0, rd = 1'b0;
    logic [3:0] dn_p = 4'h0, dn_m = 4'h0, dn_po, dn_mo, dn_oe;
    logic oc_n, xout, up_po, up_mo, up_oe, sw_n, led, irq;
    hpps_pkg::hpps_addr_t addr = 8'h00;
    hpps_pkg::hpps_word_t wdata = 32'h0, rdata, d;
    int n_fail = 0, n_compared = 0, cycles = 0;
    logic s, g, c, t, x;

    hpps_top u_hpps_top (.core_clk_i(clk), .sys_rst_i(rst), .overcurrent_in_n_i(oc_n),
        .local_supply_good_i(sup), .self_bus_i(self_p), .clk_sel_i(csel), .test_i(test),
        .xtal_in_i(xin), .xtal_out_o(xout), .upstream_plus_i(up_p), .upstream_minus_i(up_m),
        .upstream_plus_o(up_po), .upstream_minus_o(up_mo), .upstream_oe_o(up_oe),
        .downstream_plus_i(dn_p), .downstream_minus_i(dn_m), .downstream_plus_o(dn_po),
        .downstream_minus_o(dn_mo), .downstream_oe_o(dn_oe), .port_power_switch_n_o(sw_n),
        .enum_led_o(led), .irq_o(irq), .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd),
        .rdata_o(rdata));
    hpps_switch_model u_hpps_switch_model (.core_clk_i(clk), .sys_rst_i(rst),
        .port_power_switch_n_i(sw_n), .fault_i(fault), .overcurrent_in_n_o(oc_n));

    initial
    begin
        forever #50 clk = ~clk;
    end

    // ****************************************
    // Checking and bus tasks
    // ****************************************
    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        n_compared++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("BAD t=%0t %s seen %h want %h", $time, what, seen, exp);
        end
    endtask

    task automatic wr_reg(input hpps_pkg::hpps_addr_t a, input hpps_pkg::hpps_word_t v);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= v;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    task automatic rd_reg(input hpps_pkg::hpps_addr_t a, input logic [31:0] m, input logic [31:0] exp);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1 d = rdata;
        check(d & m, exp, "register read");
    endtask

    // Power pin and led are registered levels, the pin behind two sync stages on overcurrent, so poll with a bound;
    // each look is taken after the edge so the flops have settled
    task automatic wait_out(input logic want_sw, input logic want_led);
        #1;
        for (int i = 0; i < 12 && (sw_n !== want_sw || led !== want_led); i++)
        begin
            @(posedge clk);
            #1;
        end
        check({sw_n, led}, {want_sw, want_led}, "power pin and led");
    endtask

    function automatic hpps_pkg::hpps_word_t exp_status(logic sm, logic gd, logic ck, logic tm);
        return {26'h0, tm, ck, 1'b0, sm & gd, sm, 1'b0};
    endfunction

    task automatic summarize();
        $display("compared %0d failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            n_fail++;
            summarize();
        end
    end

    // ****************************************
    // Main sequence
    // ****************************************
    initial
    begin
        void'($urandom(74205));
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        #1 check({sw_n, led, irq}, 3'b100, "reset outputs");
        rd_reg(`HPPS_OFF_STATUS, 32'hc9, 32'h0);
        $display("test reset done");
        wr_reg(`HPPS_OFF_IRQ_MASK, 32'h1);
        rd_reg(`HPPS_OFF_IRQ_MASK, 32'hffffffff, 32'h1);
        wr_reg(`HPPS_OFF_CTRL, 32'h1);
        wait_out(1'b0, 1'b0);
        rd_reg(`HPPS_OFF_STATUS, 32'h1, 32'h1);
        fault <= 1'b1;
        wait_out(1'b1, 1'b0);
        // Status bit lands with the pin, the irq flop one edge later
        @(posedge clk);
        #1 check(irq, 1'b1, "irq on fault");
        rd_reg(`HPPS_OFF_HUB, 32'hffffffff, 32'h00020002);
        rd_reg(`HPPS_OFF_STATUS, 32'h8, 32'h8);
        wr_reg(`HPPS_OFF_CTRL, 32'h1);
        repeat (4) @(posedge clk);
        #1 check(sw_n, 1'b1, "power held off");
        fault <= 1'b0;
        repeat (6) @(posedge clk);
        rd_reg(`HPPS_OFF_HUB, 32'hffffffff, 32'h00020000);
        wr_reg(`HPPS_OFF_CTRL, 32'h20);
        rd_reg(`HPPS_OFF_HUB, 32'hffffffff, 32'h0);
        wr_reg(`HPPS_OFF_IRQ_STAT, 32'h1);
        rd_reg(`HPPS_OFF_IRQ_STAT, 32'h1, 32'h0);
        repeat (2) @(posedge clk);
        #1 check(irq, 1'b0, "irq cleared");
        wr_reg(`HPPS_OFF_CTRL, 32'h1);
        wr_reg(`HPPS_OFF_CTRL, 32'h2);
        wait_out(1'b1, 1'b0);
        $display("test power done");
        wr_reg(`HPPS_OFF_CTRL, 32'h4);
        wait_out(1'b1, 1'b1);
        wr_reg(`HPPS_OFF_CTRL, 32'h8);
        wait_out(1'b1, 1'b0);
        rd_reg(`HPPS_OFF_STATUS, 32'hc0, 32'h80);
        wr_reg(`HPPS_OFF_CTRL, 32'h10);
        wait_out(1'b1, 1'b1);
        rd_reg(`HPPS_OFF_CTRL, 32'hffffffff, 32'h0);
        rd_reg(8'h20, 32'hffffffff, 32'h0);
        $display("test enumeration done");
        for (int k = 0; k < 12; k++)
        begin
            {s, g, c, t, x} = 5'($urandom);
            if (k == 0)
                {s, g} = 2'b01;
            @(posedge clk);
            {self_p, sup, csel, test, xin} <= {s, g, c, t, x};
            {up_p, up_m, dn_p, dn_m} <= 10'($urandom);
            repeat (2) @(posedge clk);
            #1 check(xout, !x, "oscillator output");
            repeat (3) @(posedge clk);
            rd_reg(`HPPS_OFF_STATUS, 32'h36, exp_status(s, g, c, t));
            check({up_po, up_mo, up_oe, dn_po, dn_mo, dn_oe}, 15'h0, "pads idle");
        end
        // Supply and mode both changed after reset release; neither was cleared yet
        rd_reg(`HPPS_OFF_IRQ_STAT, 32'h6, 32'h6);
        wr_reg(`HPPS_OFF_IRQ_STAT, 32'h6);
        rd_reg(`HPPS_OFF_IRQ_STAT, 32'h6, 32'h0);
        $display("test modes done");
        summarize();
    end
endmodule // tb_hub_port_power_status_control
